// ===== pkg/fbz_pkg.sv
package fbz_pkg;
    // ----------------------------------------------------------------
    // register offsets (special function register space)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_SYS = 8'hbf;
    localparam logic [7:0] ADR_AHI = 8'hf4;
    localparam logic [7:0] ADR_ALO = 8'hf5;
    localparam logic [7:0] ADR_DAT = 8'hf6;
    localparam logic [7:0] ADR_CTL = 8'hf7;
    localparam logic [7:0] ADR_DIRECT_LO = 8'h80; // direct-only range base
    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SYS = 8'h0a;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] SYS_WMASK = 8'h0f; // bits 3..0 plain read/write
    localparam int SYS_WDOG = 7;
    localparam int SYS_DFE = 3;
    localparam int SYS_SPEN = 2;
    localparam int SYS_XRAM = 1;
    localparam int SYS_LSI = 0;
    localparam int CTL_LAUNCH = 7;
    localparam int CTL_REGION = 5;
    // ----------------------------------------------------------------
    // unlock key and flash function codes
    // ----------------------------------------------------------------
    localparam logic [7:0] KEY_A = 8'h55;
    localparam logic [7:0] KEY_B = 8'haa;
    localparam logic [1:0] KEY_ARMED = 2'h3;
    localparam logic [1:0] FN_BYTE_PROG = 2'h0;
    localparam logic [1:0] FN_ERASE_PROT = 2'h1;
    localparam logic [1:0] FN_PAGE_ERASE = 2'h2;
    localparam logic [1:0] FN_FULL_ERASE = 2'h3;
    // ----------------------------------------------------------------
    // boot zone geometry
    // ----------------------------------------------------------------
    localparam logic [16:0] FLASH_END_P1 = 17'h10000; // top of program flash + 1
    localparam int PAGE_SHIFT = 9;                    // 512-byte pages
    localparam logic [3:0] PAGES_MAX = 4'h8;          // 4KB
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] NORMAL_VECTOR = 16'h0000;
    localparam logic [1:0] REL_WAIT = 2'h2;           // synchroniser fill
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic {FBZ_IDLE, FBZ_BUSY} fbz_state_t;
endpackage

// ===== verilog/fbz_flash_boot_zone_control.sv
// How it works
// - registers answer direct-addressed accesses only
// - program and data flash both self-programmable
// - boot zone size is config times 512, at most 4KB
// - nonzero size and erased byte0 boots zone
// - low pins P2.6+P2.7 or P4.3 boot zone
// - size zero always boots normal address
// - boot zone ends at last flash address
// - lock keeps zone on full erase, blocks readback
// - parallel erase wipes all, ignoring lock
// - region bit is flash address bit 16
// - function code selects program/protect/page/full
// - launch writable only after 55 AA 55
// - latch address/data, stall until done
module fbz_flash_boot_zone_control
    import fbz_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // special function register bus from the core
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_direct,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // configuration held in flash option bytes
    input wire logic [3:0] boot_zone_size_cfg,
    input wire logic lock_cfg,
    input wire logic [7:0] code_byte0,
    // pins and events
    input wire logic p2_6_pin,
    input wire logic p2_7_pin,
    input wire logic p4_3_pin,
    input wire logic pp_erase_pin,
    input wire logic wdt_reset_evt,
    // flash macro handshake
    input wire logic flash_done,
    output logic flash_req,
    output logic [16:0] flash_addr,
    output logic [7:0] flash_data,
    output logic [1:0] flash_function_code,
    output logic flash_keep_boot,
    output logic [15:0] boot_zone_base,
    output logic cpu_stall,
    // boot and system outputs
    output logic [15:0] boot_vector,
    output logic boot_vector_valid,
    output logic pp_read_allow,
    output logic pp_erase_all,
    output logic data_flash_on,
    output logic self_prog_enable,
    output logic extra_ram_enable,
    output logic latch_strobe_inhibit
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sys;        // system control
        logic [7:0] ahi;        // flash address high
        logic [7:0] alo;        // flash address low
        logic [7:0] dat;        // flash write data
        logic region;           // flash region select
        logic [1:0] func;       // flash function code
        logic [1:0] key;        // unlock progress, 3 = armed
        fbz_state_t st;         // sequencer
        logic busy;             // launch bit / stall
        logic req;              // one-cycle request to macro
        logic [16:0] laddr;     // latched address
        logic [7:0] ldat;       // latched data
        logic [1:0] lfunc;      // latched function
        logic keep;             // latched boot zone keep
        logic [7:0] rdata;      // registered read data
        logic hit;              // registered decode hit
        logic [3:0] s1;         // synchroniser stage 1
        logic [3:0] s2;         // synchroniser stage 2
        logic [1:0] rel;        // cycles since reset release
        logic [15:0] base;      // boot zone base
        logic [15:0] vec;       // chosen reset vector
        logic vok;              // vector valid
        logic ppe;              // parallel erase request
        logic rdok;             // parallel readback allowed
    } fbz_state_s_t;

    fbz_state_s_t q, d;
    logic wr_ok; // qualified write
    logic rd_ok; // qualified read
    logic [3:0] pages; // clamped page count
    logic [16:0] base17; // computed base, 17 bits
    logic pin_force; // synchronised pin boot request

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // indirect accesses never reach this block
        wr_ok = sfr_wr & sfr_direct;
        rd_ok = sfr_rd & sfr_direct;
        d.req = 1'b0;
        // two flops before any pin is looked at
        d.s1 = {pp_erase_pin, p4_3_pin, p2_7_pin, p2_6_pin};
        d.s2 = q.s1;
        pin_force = (~q.s2[0] & ~q.s2[1]) | ~q.s2[2];
        // configs above 4KB are clamped, no larger zone exists
        pages = (boot_zone_size_cfg > PAGES_MAX) ? PAGES_MAX : boot_zone_size_cfg;
        base17 = FLASH_END_P1 - {4'h0, pages, 9'h000};
        // zone runs from base up to the last address
        d.base = base17[15:0];
        // register writes
        if (wr_ok) begin
            unique case (sfr_addr)
                ADR_SYS: begin
                    // watchdog flag only clears by writing zero
                    d.sys = (sfr_wdata & SYS_WMASK)
                        | {q.sys[SYS_WDOG] & sfr_wdata[SYS_WDOG], 7'h00};
                end
                ADR_AHI: d.ahi = sfr_wdata;
                ADR_ALO: d.alo = sfr_wdata;
                ADR_DAT: begin
                    d.dat = sfr_wdata;
                    // unlock sequence tracker
                    if (sfr_wdata == KEY_A) begin
                        d.key = (q.key == 2'h2) ? KEY_ARMED : 2'h1;
                    end else if (sfr_wdata == KEY_B && q.key == 2'h1) begin
                        d.key = 2'h2;
                    end else begin
                        d.key = 2'h0;
                    end
                end
                ADR_CTL: begin
                    if (!q.busy) begin
                        d.region = sfr_wdata[CTL_REGION];
                        d.func = sfr_wdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // hardware set wins over a software clear
        if (wdt_reset_evt) begin
            d.sys[SYS_WDOG] = 1'b1;
        end
        // sequencer
        unique case (q.st)
            FBZ_IDLE: begin
                // launch bit stays read-only unless armed and enabled
                if (wr_ok && sfr_addr == ADR_CTL && sfr_wdata[CTL_LAUNCH]
                        && q.key == KEY_ARMED && q.sys[SYS_SPEN]) begin
                    d.st = FBZ_BUSY;
                    d.busy = 1'b1;
                    d.req = 1'b1;
                    d.key = 2'h0;
                    // both regions reachable, region bit is bit 16
                    d.laddr = {sfr_wdata[CTL_REGION], q.ahi, q.alo};
                    d.ldat = q.dat;
                    d.lfunc = sfr_wdata[1:0];
                    // lock spares the boot zone on full erase
                    d.keep = lock_cfg && (pages != 4'h0)
                        && (sfr_wdata[1:0] == FN_FULL_ERASE);
                end
            end
            FBZ_BUSY: begin
                // core stays stalled until the macro finishes
                if (flash_done) begin
                    d.st = FBZ_IDLE;
                    d.busy = 1'b0;
                end
            end
        endcase
        // read data, registered one cycle after the strobe
        d.hit = (rd_ok | wr_ok) & (sfr_addr == ADR_SYS || sfr_addr == ADR_AHI
            || sfr_addr == ADR_ALO || sfr_addr == ADR_DAT || sfr_addr == ADR_CTL);
        if (rd_ok) begin
            unique case (sfr_addr)
                ADR_SYS: d.rdata = q.sys;
                ADR_AHI: d.rdata = q.ahi;
                ADR_ALO: d.rdata = q.alo;
                ADR_DAT: d.rdata = q.dat;
                ADR_CTL: d.rdata = {q.busy, 1'b0, q.region, 3'h0, q.func};
                default: d.rdata = RST_REG;
            endcase
        end
        // readback and erase from the parallel programmer
        d.rdok = ~lock_cfg;
        d.ppe = q.s2[3];
        // boot vector chosen once, after the synchroniser has filled
        if (!q.vok) begin
            if (q.rel == REL_WAIT) begin
                d.vok = 1'b1;
                if (pages == 4'h0) begin
                    d.vec = NORMAL_VECTOR;
                end else if (code_byte0 == ERASED_BYTE || pin_force) begin
                    d.vec = base17[15:0];
                end else begin
                    d.vec = NORMAL_VECTOR;
                end
            end else begin
                d.rel = q.rel + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // boot pins idle high, so their sync bits reset to one, erase bit to zero
            q <= '{sys: RST_SYS, ahi: RST_REG, alo: RST_REG, dat: RST_REG,
                region: 1'b0, func: FN_BYTE_PROG, key: 2'h0, st: FBZ_IDLE,
                busy: 1'b0, req: 1'b0, laddr: 17'h00000, ldat: RST_REG,
                lfunc: FN_BYTE_PROG, keep: 1'b0, rdata: RST_REG, hit: 1'b0,
                s1: 4'h7, s2: 4'h7, rel: 2'h0, base: 16'h0000,
                vec: NORMAL_VECTOR, vok: 1'b0, ppe: 1'b0, rdok: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign sfr_rdata = q.rdata;
    assign sfr_hit = q.hit;
    assign flash_req = q.req;
    assign flash_addr = q.laddr;
    assign flash_data = q.ldat;
    assign flash_function_code = q.lfunc;
    assign flash_keep_boot = q.keep;
    assign boot_zone_base = q.base;
    assign cpu_stall = q.busy;
    assign boot_vector = q.vec;
    assign boot_vector_valid = q.vok;
    assign pp_read_allow = q.rdok;
    assign pp_erase_all = q.ppe;
    assign data_flash_on = q.sys[SYS_DFE];
    assign self_prog_enable = q.sys[SYS_SPEN];
    assign extra_ram_enable = q.sys[SYS_XRAM];
    assign latch_strobe_inhibit = q.sys[SYS_LSI];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_indirect;
        @(posedge clk) disable iff (!rst_n)
        (sfr_wr && !sfr_direct && !sfr_rd) |=> (q.dat == $past(q.dat)) && !q.hit;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect access reached registers");

    property p_key;
        @(posedge clk) disable iff (!rst_n)
        $rose(q.busy) |-> ($past(q.key) == KEY_ARMED) && q.key == 2'h0;
    endproperty
    a_key: assert property (p_key) else $error("launch without unlock");

    property p_req_once;
        @(posedge clk) disable iff (!rst_n)
        q.req |-> q.busy ##1 !q.req;
    endproperty
    a_req_once: assert property (p_req_once) else $error("request not single");

    property p_done;
        @(posedge clk) disable iff (!rst_n)
        (q.busy && flash_done) |=> !q.busy && q.st == FBZ_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("stall not released");

    property p_latch;
        @(posedge clk) disable iff (!rst_n)
        q.req |-> q.laddr[15:0] == {$past(q.ahi), $past(q.alo)} && q.ldat == $past(q.dat);
    endproperty
    a_latch: assert property (p_latch) else $error("address or data not latched");

    property p_size0;
        @(posedge clk) disable iff (!rst_n)
        ($rose(q.vok) && $past(boot_zone_size_cfg) == 4'h0) |-> q.vec == NORMAL_VECTOR;
    endproperty
    a_size0: assert property (p_size0) else $error("size zero left normal vector");

    property p_base;
        @(posedge clk) disable iff (!rst_n)
        ($rose(q.vok) && q.vec != NORMAL_VECTOR) |-> q.vec == q.base;
    endproperty
    a_base: assert property (p_base) else $error("boot vector not zone base");

    property p_wdr;
        @(posedge clk) disable iff (!rst_n)
        wdt_reset_evt |=> q.sys[SYS_WDOG];
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog flag lost");

    property p_valid_time;
        @(posedge clk) disable iff (!rst_n)
        $rose(q.vok) |-> $past(q.rel) == REL_WAIT;
    endproperty
    a_valid_time: assert property (p_valid_time) else $error("vector chosen early");
endmodule // fbz_flash_boot_zone_control

// ===== verification/fbz_flash_model.sv
// --------------------------------------------------------------
// flash macro stand-in: answers each start pulse lat+1 cycles after it is sampled
// --------------------------------------------------------------
module fbz_flash_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flash_req,
    input wire logic [3:0] lat,
    output logic flash_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q; // cycles left in the current operation, 0 = idle
    // a late answer keeps the core stalled longer, exercising the wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt_q == 4'h1); // one done pulse per operation
            if (flash_req) begin
                cnt_q <= lat + 4'h1;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // fbz_flash_model

// ===== verification/fbz_flash_boot_zone_control_tb.sv
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); bad_count++; end end
module fbz_flash_boot_zone_control_tb import fbz_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic clk, rst_n, sfr_wr, sfr_rd, sfr_direct, sfr_hit, lock_cfg, rhit;
    logic p2_6_pin, p2_7_pin, p4_3_pin, pp_erase_pin, wdt_reset_evt, flash_done;
    logic flash_req, flash_keep_boot, cpu_stall, boot_vector_valid, pp_read_allow;
    logic pp_erase_all, data_flash_on, self_prog_enable, extra_ram_enable;
    logic latch_strobe_inhibit;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, code_byte0, flash_data, rdat, hi;
    logic [3:0] boot_zone_size_cfg, lat;
    logic [16:0] flash_addr;
    logic [1:0] flash_function_code;
    logic [15:0] boot_zone_base, boot_vector;
    int bad_count, cmp_count;
    fbz_flash_boot_zone_control dut_u (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_direct, .sfr_rdata, .sfr_hit, .boot_zone_size_cfg, .lock_cfg,
        .code_byte0, .p2_6_pin, .p2_7_pin, .p4_3_pin, .pp_erase_pin, .wdt_reset_evt,
        .flash_done, .flash_req, .flash_addr, .flash_data, .flash_function_code,
        .flash_keep_boot, .boot_zone_base, .cpu_stall, .boot_vector, .boot_vector_valid,
        .pp_read_allow, .pp_erase_all, .data_flash_on, .self_prog_enable,
        .extra_ram_enable, .latch_strobe_inhibit);
    fbz_flash_model flash_u (.clk, .rst_n, .flash_req, .lat, .flash_done);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // --------------------------------------------------------------
    // bus and wait tasks
    // --------------------------------------------------------------
    // one access: strobe held across exactly one sampling edge
    task automatic acc(input logic w, input logic dir, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_direct <= dir;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
        rdat = sfr_rdata;
        rhit = sfr_hit;
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [7:0] ex);
        acc(1'b0, 1'b1, a, 8'h00);
        `CHK("read data", ex, rdat)
        `CHK("read hit", 1'b1, rhit)
    endtask
    task automatic key(input logic [7:0] third);
        acc(1'b1, 1'b1, ADR_DAT, KEY_A);
        acc(1'b1, 1'b1, ADR_DAT, KEY_B);
        acc(1'b1, 1'b1, ADR_DAT, third);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return flash_req;
            1: return cpu_stall;
            2: return boot_vector_valid;
            default: return pp_erase_all;
        endcase
    endfunction
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic waitsig(input int sel, input logic lvl);
        int i;
        for (i = 0; i < 60; i++) begin
            if (sig(sel) === lvl) break;
            @(posedge clk);
            #1;
        end
        if (i == 60) begin
            $display("mismatch wait %0d expected %b seen timeout", sel, lvl);
            bad_count++;
            give_verdict();
        end
    endtask
    // reset with given options and pins, then check the chosen vector
    task automatic do_rst(input logic [3:0] s, input logic [7:0] b, input logic [2:0] p);
        logic [15:0] eb;
        eb = 16'(FLASH_END_P1 - (17'(s) << PAGE_SHIFT));
        @(posedge clk);
        rst_n <= 1'b0;
        boot_zone_size_cfg <= s;
        code_byte0 <= b;
        {p2_6_pin, p2_7_pin, p4_3_pin} <= p;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        waitsig(2, 1'b1);
        if (s != 4'h0) `CHK("zone base", eb, boot_zone_base)
        if (s == 4'h0 || !(b == ERASED_BYTE || p[2:1] == 2'b00 || !p[0])) eb = NORMAL_VECTOR;
        `CHK("boot vector", eb, boot_vector)
        @(posedge clk);
        {p2_6_pin, p2_7_pin, p4_3_pin} <= 3'b111;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_n, sfr_wr, sfr_rd, lock_cfg, pp_erase_pin, wdt_reset_evt} = '0;
        {sfr_direct, p2_6_pin, p2_7_pin, p4_3_pin} = 4'hf;
        {sfr_addr, sfr_wdata, code_byte0, boot_zone_size_cfg, lat} = '0;
        bad_count = 0;
        cmp_count = 0;
        do_rst(4'h7, 8'hff, 3'b111);
        chkrd(ADR_SYS, RST_SYS);
        foreach (hi[i]) if (i < 4) chkrd(ADR_AHI + 8'(i), RST_REG);
        // indirect accesses and an unmapped place must stay silent
        acc(1'b1, 1'b0, ADR_AHI, 8'h5a);
        chkrd(ADR_AHI, RST_REG);
        acc(1'b0, 1'b0, ADR_SYS, 8'h00);
        `CHK("indirect hit", 1'b0, rhit)
        acc(1'b0, 1'b1, 8'h90, 8'h00);
        `CHK("unmapped", 9'h000, {rhit, rdat})
        // launch refused while self-programming is off, then with a broken key
        key(KEY_A);
        acc(1'b1, 1'b1, ADR_CTL, 8'h80);
        chkrd(ADR_CTL, 8'h00);
        acc(1'b1, 1'b1, ADR_SYS, 8'h0f);
        `CHK("sys bits", 4'hf, {data_flash_on, self_prog_enable, extra_ram_enable,
            latch_strobe_inhibit})
        key(8'h33);
        acc(1'b1, 1'b1, ADR_CTL, 8'h80);
        chkrd(ADR_CTL, 8'h00);
        // watchdog flag sets from the event and clears by writing 0
        @(posedge clk);
        wdt_reset_evt <= 1'b1;
        @(posedge clk);
        wdt_reset_evt <= 1'b0;
        chkrd(ADR_SYS, 8'h8f);
        acc(1'b1, 1'b1, ADR_SYS, 8'h0e);
        chkrd(ADR_SYS, 8'h0e);
        // every function code, both regions, prompt and slow flash
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            lock_cfg <= k[1];
            lat <= k[0] ? 4'h9 : 4'h3;
            hi = 8'h10 + 8'(k);
            acc(1'b1, 1'b1, ADR_AHI, hi);
            acc(1'b1, 1'b1, ADR_ALO, 8'h3c);
            key(KEY_A);
            acc(1'b1, 1'b1, ADR_CTL, {2'b10, k[0], 3'b000, k[1:0]});
            waitsig(0, 1'b1);
            `CHK("flash addr", {k[0], hi, 8'h3c}, flash_addr)
            `CHK("function", k[1:0], flash_function_code)
            `CHK("data stall", {KEY_A, 1'b1}, {flash_data, cpu_stall})
            `CHK("keep zone", 1'(k == 3), flash_keep_boot)
            `CHK("readback", !k[1], pp_read_allow)
            chkrd(ADR_CTL, {2'b10, k[0], 3'b000, k[1:0]});
            waitsig(1, 1'b0);
            chkrd(ADR_CTL, {2'b00, k[0], 3'b000, k[1:0]});
        end
        // parallel programmer erase request goes out even with lock set
        @(posedge clk);
        pp_erase_pin <= 1'b1;
        waitsig(3, 1'b1);
        @(posedge clk);
        pp_erase_pin <= 1'b0;
        do_rst(4'h8, 8'h00, 3'b111);
        do_rst(4'h8, 8'h00, 3'b001);
        do_rst(4'h1, 8'h00, 3'b110);
        do_rst(4'h2, 8'h00, 3'b011);
        do_rst(4'h0, 8'hff, 3'b000);
        give_verdict();
    end
endmodule // fbz_flash_boot_zone_control_tb
